// ---- hdl/pending_id_pkg.sv ----
// package: register map, field layout, reset values and special identifiers for the pending id readout
package pending_id_pkg;
    // ****************************************
    // register offsets (byte addresses, own choice)
    // ****************************************
    localparam logic [7:0] OFS_HIGHEST_PENDING = 8'h00;
    localparam logic [7:0] OFS_ALIASED_SPLIT = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
    // ****************************************
    // field layout
    // ****************************************
    localparam int ID_W = 10;
    localparam int CORE_W = 3;
    localparam int ID_LSB = 0;
    localparam int CORE_LSB = 10;
    localparam int SPLIT_W = 3;
    localparam int CTL_ACK_BIT = 0;
    localparam int CTL_CPU_G0_BIT = 1;
    localparam int CTL_CPU_G1_BIT = 2;
    localparam int CTL_DIST_G0_BIT = 3;
    localparam int CTL_DIST_G1_BIT = 4;
    localparam int CTL_COMMON_BIT = 5;
    localparam int CTL_W = 6;
    localparam int IRQ_W = 3;
    localparam int IRQ_NEW_TOP_BIT = 0;
    localparam int IRQ_NONSEC_DENIED_BIT = 1;
    localparam int IRQ_BAD_ADDR_BIT = 2;
    // ****************************************
    // special identifiers and reset values
    // ****************************************
    localparam logic [9:0] ID_SPURIOUS_GRP1 = 10'h3fe;
    localparam logic [9:0] ID_NONE = 10'h3ff;
    localparam logic [9:0] ID_LAST_SOFT = 10'h00f;
    localparam logic [2:0] SPLIT_MIN = 3'h0;
    localparam logic [2:0] SPLIT_RESET = 3'h1;
    localparam logic [5:0] CTL_RESET = 6'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [7:0] PRIO_MASK_FULL = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pending_id_pkg

// ---- hdl/pending_id_readout.sv ----
// pending id readout: highest pending report, aliased split point, axi4-lite slave
// What this block does
// - never report an interrupt that is both active and pending
// - pending identifier in bits 9..0, bits 31..13 reserved zero
// - multiprocessor: requesting core in bits 12..10 for software interrupts, else zero
// - group 1 top: non-secure gives id; secure gives 1022 unless ack control set
// - group 0 top: non-secure gives 1023; secure gives the id
// - invalid read returns 1022 or 1023; nothing pending returns 1023
// - without security extensions every read takes the secure outcome
// - distributor group enable clear substitutes 1023 first
// - optionally interface group enable clear also substitutes 1023
// - ids 0..15 are software interrupts; core field zero otherwise
// - aliased split point resets to minimum plus one
// - with security extensions only secure accesses reach aliased split point
// - aliased split point shares storage with non-secure split point
// - aliased split point access independent of common split point bit
// - common split point set: aliased register has no preemption effect
// - not implemented: aliased address reads zero, ignores writes
// - low three bits split 8-bit priority into group and subpriority
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pending_id_readout
    import pending_id_pkg::*;
#(
    parameter bit HAS_SECURITY = 1'b1,
    parameter bit MULTI_CORE = 1'b1,
    parameter bit HAS_ALIAS = 1'b1,
    parameter bit MASK_BY_IFACE = 1'b1
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // axi4-lite write address and data
    input wire logic [7:0] s_awaddr_i,
    input wire logic [2:0] s_awprot_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    // axi4-lite write response
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    // axi4-lite read
    input wire logic [7:0] s_araddr_i,
    input wire logic [2:0] s_arprot_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    // pending selector, same clock domain
    input wire logic top_valid_i,
    input wire logic [9:0] top_id_i,
    input wire logic top_group_one_i,
    input wire logic top_active_i,
    input wire logic [2:0] top_core_i,
    // split point and preemption view
    output logic [2:0] group_one_split_o,
    output logic [7:0] group_prio_mask_o,
    // interrupt
    output logic irq_o
);
    // ****************************************
    // state
    // ****************************************
    logic [5:0] ctl_r;
    logic [2:0] split_ns_r;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_en_r;
    logic [9:0] last_id_r;
    logic aw_held_r;
    logic w_held_r;
    logic [7:0] awaddr_r;
    logic aw_nonsec_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_do;
    logic rd_do;
    logic [9:0] report_id;
    logic [2:0] report_core;
    logic [31:0] rd_word;
    logic rd_bad;
    logic rd_denied;
    logic wr_bad;
    logic wr_denied;
    logic nonsec_rd;
    logic [2:0] eff_split;
    logic [2:0] irq_set;
    logic aw_held_nxt;
    logic w_held_nxt;
    logic bvalid_nxt;

    // ****************************************
    // highest pending report
    // ****************************************
    // secure reading is forced when there are no security extensions
    assign nonsec_rd = HAS_SECURITY & s_arprot_i[1];

    // substitution chain, read only view with no side effects
    always_comb begin
        report_id = ID_NONE;
        if (top_valid_i && !top_active_i) begin
            report_id = top_id_i;
            if (top_group_one_i ? !ctl_r[CTL_DIST_G1_BIT] : !ctl_r[CTL_DIST_G0_BIT]) begin
                report_id = ID_NONE;
            end else if (MASK_BY_IFACE && (top_group_one_i ? !ctl_r[CTL_CPU_G1_BIT]
                                                          : !ctl_r[CTL_CPU_G0_BIT])) begin
                report_id = ID_NONE;
            end else if (!top_group_one_i) begin
                if (nonsec_rd) begin
                    report_id = ID_NONE;
                end
            end else if (!nonsec_rd && !ctl_r[CTL_ACK_BIT]) begin
                report_id = ID_SPURIOUS_GRP1;
            end
        end
    end

    // core field only for software interrupts in a multiprocessor build
    assign report_core = (MULTI_CORE && report_id <= ID_LAST_SOFT) ? top_core_i : 3'h0;

    // ****************************************
    // read decode
    // ****************************************
    // the alias and the non-secure split point are one store
    assign eff_split = split_ns_r;
    // read word and error flags for the address on the read channel
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_bad = 1'b0;
        rd_denied = 1'b0;
        if (s_araddr_i[7:2] == OFS_HIGHEST_PENDING[7:2]) begin
            rd_word[CORE_LSB +: CORE_W] = report_core;
            rd_word[ID_LSB +: ID_W] = report_id;
        end else if (s_araddr_i[7:2] == OFS_ALIASED_SPLIT[7:2]) begin
            if (!HAS_ALIAS) begin
                rd_word = 32'h0000_0000;
            end else if (nonsec_rd) begin
                rd_denied = 1'b1;
            end else begin
                rd_word[SPLIT_W-1:0] = split_ns_r;
            end
        end else if (s_araddr_i[7:2] == OFS_CONTROL[7:2]) begin
            rd_word[CTL_W-1:0] = ctl_r;
        end else if (s_araddr_i[7:2] == OFS_IRQ_STATUS[7:2]) begin
            rd_word[IRQ_W-1:0] = irq_stat_r;
        end else if (s_araddr_i[7:2] == OFS_IRQ_ENABLE[7:2]) begin
            rd_word[IRQ_W-1:0] = irq_en_r;
        end else if (s_araddr_i[7:2] == OFS_IRQ_CLEAR[7:2]) begin
            rd_word = 32'h0000_0000;
        end else begin
            rd_bad = 1'b1;
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    // read taken at this edge
    assign rd_do = s_arvalid_i && s_arready_o;
    // one-cycle arready, data latched at the take and held until rready
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_arready_o <= 1'b0;
            s_rvalid_o <= 1'b0;
            s_rdata_o <= 32'h0000_0000;
            s_rresp_o <= RESP_OKAY;
        end else begin
            s_arready_o <= !s_arready_o && !s_rvalid_o && s_arvalid_i;
            if (rd_do) begin
                s_rvalid_o <= 1'b1;
                s_rdata_o <= (rd_bad || rd_denied) ? 32'h0000_0000 : rd_word;
                s_rresp_o <= rd_bad ? RESP_SLVERR : RESP_OKAY;
            end else if (s_rvalid_o && s_rready_i) begin
                s_rvalid_o <= 1'b0;
            end
        end
    end

    // ****************************************
    // axi4-lite write channels, taken in either order
    // ****************************************
    // address and data beats held until the write executes
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= 8'h00;
            aw_nonsec_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_awvalid_i && s_awready_o) begin
                aw_held_r <= 1'b1;
                awaddr_r <= s_awaddr_i;
                aw_nonsec_r <= HAS_SECURITY & s_awprot_i[1];
            end else if (wr_do) begin
                aw_held_r <= 1'b0;
            end
            if (s_wvalid_i && s_wready_o) begin
                w_held_r <= 1'b1;
                wdata_r <= s_wdata_i;
                wstrb_r <= s_wstrb_i;
            end else if (wr_do) begin
                w_held_r <= 1'b0;
            end
        end
    end

    assign wr_do = aw_held_r && w_held_r && !s_bvalid_o;

    // next state of the write holds and the response, so both readies can be flops
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt = w_held_r;
        bvalid_nxt = s_bvalid_o;
        if (s_awvalid_i && s_awready_o) begin
            aw_held_nxt = 1'b1;
        end else if (wr_do) begin
            aw_held_nxt = 1'b0;
        end
        if (s_wvalid_i && s_wready_o) begin
            w_held_nxt = 1'b1;
        end else if (wr_do) begin
            w_held_nxt = 1'b0;
        end
        if (wr_do) begin
            bvalid_nxt = 1'b1;
        end else if (s_bvalid_o && s_bready_i) begin
            bvalid_nxt = 1'b0;
        end
    end

    // readies as flops: low while a beat is held or the response waits
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_awready_o <= 1'b0;
            s_wready_o <= 1'b0;
        end else begin
            s_awready_o <= !aw_held_nxt && !bvalid_nxt;
            s_wready_o <= !w_held_nxt && !bvalid_nxt;
        end
    end

    // write decode flags
    always_comb begin
        wr_bad = 1'b0;
        wr_denied = 1'b0;
        if (awaddr_r[7:2] == OFS_ALIASED_SPLIT[7:2]) begin
            wr_denied = HAS_ALIAS && aw_nonsec_r;
        end else if (awaddr_r[7:2] != OFS_HIGHEST_PENDING[7:2] && awaddr_r[7:2] != OFS_CONTROL[7:2]
                     && awaddr_r[7:2] != OFS_IRQ_STATUS[7:2] && awaddr_r[7:2] != OFS_IRQ_CLEAR[7:2]
                     && awaddr_r[7:2] != OFS_IRQ_ENABLE[7:2]) begin
            wr_bad = 1'b1;
        end
    end

    // write response
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_bvalid_o <= 1'b0;
            s_bresp_o <= RESP_OKAY;
        end else if (wr_do) begin
            s_bvalid_o <= 1'b1;
            s_bresp_o <= wr_bad ? RESP_SLVERR : RESP_OKAY;
        end else if (s_bvalid_o && s_bready_i) begin
            s_bvalid_o <= 1'b0;
        end
    end

    // ****************************************
    // control and split point registers
    // ****************************************
    // report offset has no write path, so writes there fall away
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctl_r <= CTL_RESET;
            split_ns_r <= SPLIT_RESET;
            irq_en_r <= IRQ_RESET;
        end else if (wr_do && wstrb_r[0]) begin
            if (awaddr_r[7:2] == OFS_CONTROL[7:2]) begin
                ctl_r <= wdata_r[CTL_W-1:0];
            end else if (awaddr_r[7:2] == OFS_ALIASED_SPLIT[7:2] && HAS_ALIAS && !wr_denied) begin
                // below the minimum clamps up, one shared store
                split_ns_r <= (wdata_r[2:0] < SPLIT_MIN) ? SPLIT_MIN : wdata_r[2:0];
            end else if (awaddr_r[7:2] == OFS_IRQ_ENABLE[7:2]) begin
                irq_en_r <= wdata_r[IRQ_W-1:0];
            end
        end
    end

    // ****************************************
    // preemption view of the group one split point
    // ****************************************
    // mask of priority bits that form the group priority
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            group_one_split_o <= SPLIT_RESET;
            group_prio_mask_o <= PRIO_MASK_FULL;
        end else begin
            // common bit set: the alias stops steering preemption
            group_one_split_o <= ctl_r[CTL_COMMON_BIT] ? 3'h0 : eff_split;
            group_prio_mask_o <= ctl_r[CTL_COMMON_BIT] ? 8'hff
                               : (8'hff << (eff_split == 3'h0 ? 3'h0 : eff_split - 3'h1));
        end
    end

    // ****************************************
    // events and interrupt
    // ****************************************
    // last reported id, to spot a new top
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            last_id_r <= ID_NONE;
        end else begin
            last_id_r <= report_id;
        end
    end

    // one set pulse per event kind, a single driver for the whole vector
    always_comb begin
        irq_set = IRQ_RESET;
        irq_set[IRQ_NEW_TOP_BIT] = (report_id != last_id_r) && (report_id != ID_NONE);
        irq_set[IRQ_NONSEC_DENIED_BIT] = (rd_do && rd_denied) || (wr_do && wr_denied);
        irq_set[IRQ_BAD_ADDR_BIT] = (rd_do && rd_bad) || (wr_do && wr_bad);
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_r <= IRQ_RESET;
        end else if (wr_do && wstrb_r[0] && awaddr_r[7:2] == OFS_IRQ_CLEAR[7:2]) begin
            irq_stat_r <= (irq_stat_r & ~wdata_r[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    // level interrupt from enabled status bits
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((irq_stat_r | irq_set) & irq_en_r);
        end
    end
endmodule : pending_id_readout
`default_nettype wire

// ---- dv/pending_id_readout_properties.sv ----
// checker: read channel and report properties of the pending id readout
`timescale 1ns/1ps
`default_nettype none
module pending_id_props
    import pending_id_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // read channel
    input wire logic [7:0] s_araddr_i,
    input wire logic s_arvalid_i,
    input wire logic s_arready_o,
    input wire logic [31:0] s_rdata_o,
    input wire logic s_rvalid_o,
    input wire logic s_rready_i,
    // selector and split view
    input wire logic top_valid_i,
    input wire logic [9:0] top_id_i,
    input wire logic top_active_i,
    input wire logic [2:0] group_one_split_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic rep_rd;
    // report read taken at this edge
    assign rep_rd = s_arvalid_i && s_arready_o && (s_araddr_i == OFS_HIGHEST_PENDING);
    read_hold_a: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
        else $error("read data dropped before taken");
    read_answer_a: assert property (s_arvalid_i && s_arready_o |=> s_rvalid_o)
        else $error("read answer late");
    ar_pulse_a: assert property (s_arready_o |=> !s_arready_o)
        else $error("arready longer than one cycle");
    reserved_zero_a: assert property (s_rvalid_o |-> s_rdata_o[31:13] == 19'h00000)
        else $error("reserved bits set");
    none_pending_a: assert property (rep_rd && !top_valid_i |=> s_rdata_o[9:0] == ID_NONE)
        else $error("idle report not 1023");
    active_hidden_a: assert property (rep_rd && top_active_i |=> s_rdata_o[9:0] == ID_NONE)
        else $error("active interrupt reported");
    core_zero_a: assert property (rep_rd && top_id_i > ID_LAST_SOFT |=> s_rdata_o[12:10] == 3'h0)
        else $error("core field set for non-soft id");
    split_reset_a: assert property ($fell(rst_i) |-> group_one_split_o == SPLIT_RESET)
        else $error("split point reset value wrong");
    cover property (rep_rd && top_valid_i);
    cover property (rep_rd && top_active_i);
    cover property (s_rvalid_o && s_rready_i);
endmodule : pending_id_props
bind pending_id_readout pending_id_props i_props (.clk_sys_i, .rst_i, .s_araddr_i, .s_arvalid_i, .s_arready_o,
    .s_rdata_o, .s_rvalid_o, .s_rready_i, .top_valid_i, .top_id_i, .top_active_i, .group_one_split_o);
`default_nettype wire

// ---- dv/core_master.sv ----
// partner: processor core issuing axi4-lite reads and writes
`timescale 1ns/1ps
`default_nettype none
module core_master (
    // clock
    input wire logic clk_sys_i
);
    logic [7:0] awaddr = 8'h00;
    logic [2:0] awprot = 3'h0;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic [7:0] araddr = 8'h00;
    logic [2:0] arprot = 3'h0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    // write: offer address and data together, drop each when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ns, output logic [1:0] resp);
        int n;
        @(posedge clk_sys_i);
        awaddr <= a;
        awprot <= {1'b0, ns, 1'b0};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys_i);
            if (awvalid && tb_top.i_dut.s_awready_o) awvalid <= 1'b0;
            if (wvalid && tb_top.i_dut.s_wready_o) wvalid <= 1'b0;
            if (tb_top.i_dut.s_bvalid_o) begin
                resp = tb_top.i_dut.s_bresp_o;
                bready <= 1'b0;
                return;
            end
        end
        resp = 2'h3;
        tb_top.fails++;
        tb_top.stop_test();
    endtask : wr
    // read: hold request until taken, rready until data seen
    task automatic rd(input logic [7:0] a, input logic ns, output logic [31:0] d, output logic [1:0] resp);
        int n;
        @(posedge clk_sys_i);
        araddr <= a;
        arprot <= {1'b0, ns, 1'b0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_sys_i);
            if (arvalid && tb_top.i_dut.s_arready_o) arvalid <= 1'b0;
            if (tb_top.i_dut.s_rvalid_o) begin
                d = tb_top.i_dut.s_rdata_o;
                resp = tb_top.i_dut.s_rresp_o;
                rready <= 1'b0;
                return;
            end
        end
        d = 32'h00000000;
        resp = 2'h3;
        tb_top.fails++;
        tb_top.stop_test();
    endtask : rd
endmodule : core_master
`default_nettype wire

// ---- dv/tb_top.sv ----
// testbench: register-level checks of the pending id readout
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import pending_id_pkg::*;
;
    localparam logic [31:0] EN_ALL = 32'((1 << CTL_CPU_G0_BIT) | (1 << CTL_CPU_G1_BIT) |
        (1 << CTL_DIST_G0_BIT) | (1 << CTL_DIST_G1_BIT) | (1 << CTL_ACK_BIT));
    localparam logic [31:0] ST_ALL = 32'((1 << IRQ_NEW_TOP_BIT) | (1 << IRQ_NONSEC_DENIED_BIT));
    localparam logic [31:0] BAD = 32'(1 << IRQ_BAD_ADDR_BIT);
    logic clk_sys_i;
    logic rst_i = 1'b1;
    logic top_valid = 1'b0;
    logic [9:0] top_id = 10'h000;
    logic top_grp1 = 1'b0;
    logic top_active = 1'b0;
    logic [2:0] top_core = 3'h0;
    logic [2:0] split;
    logic [7:0] prio_mask;
    logic irq;
    logic [31:0] d;
    logic [1:0] r;
    int fails = 0;
    int num_checks = 0;
    // clock, 20 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    core_master i_core (.clk_sys_i(clk_sys_i));
    pending_id_readout i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .s_awaddr_i(i_core.awaddr), .s_awprot_i(i_core.awprot), .s_awvalid_i(i_core.awvalid), .s_awready_o(),
        .s_wdata_i(i_core.wdata), .s_wstrb_i(4'hf), .s_wvalid_i(i_core.wvalid), .s_wready_o(),
        .s_bresp_o(), .s_bvalid_o(), .s_bready_i(i_core.bready),
        .s_araddr_i(i_core.araddr), .s_arprot_i(i_core.arprot), .s_arvalid_i(i_core.arvalid), .s_arready_o(),
        .s_rdata_o(), .s_rresp_o(), .s_rvalid_o(), .s_rready_i(i_core.rready),
        .top_valid_i(top_valid), .top_id_i(top_id), .top_group_one_i(top_grp1), .top_active_i(top_active),
        .top_core_i(top_core), .group_one_split_o(split), .group_prio_mask_o(prio_mask), .irq_o(irq));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic ns, input logic [31:0] exp);
        i_core.rd(a, ns, d, r);
        chk(nm, exp, d);
    endtask : rd_chk
    task automatic rep(input logic ns, input logic [31:0] exp);
        rd_chk("report", OFS_HIGHEST_PENDING, ns, exp);
    endtask : rep
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] v, input logic ns);
        i_core.wr(a, v, ns, r);
        chk("bresp", 32'(RESP_OKAY), 32'(r));
    endtask : wr_chk
    task automatic top(input logic v, input logic [9:0] id, input logic g1, input logic act, input logic [2:0] c);
        @(posedge clk_sys_i);
        top_valid <= v;
        top_id <= id;
        top_grp1 <= g1;
        top_active <= act;
        top_core <= c;
    endtask : top
    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk("irq", 32'(exp), 32'(irq));
    endtask : irq_chk
    task automatic stop_test;
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_chk("alias", OFS_ALIASED_SPLIT, 1'b0, 32'(SPLIT_RESET));
        chk("mask", 32'h000000ff, 32'(prio_mask));
        top(1'b1, 10'h005, 1'b0, 1'b0, 3'h3);
        rep(1'b0, 32'(ID_NONE));
        wr_chk(OFS_CONTROL, EN_ALL & ~32'(1 << CTL_ACK_BIT), 1'b0);
        rep(1'b0, 32'h00000c05);
        rep(1'b1, 32'(ID_NONE));
        top(1'b1, 10'h028, 1'b1, 1'b0, 3'h5);
        rep(1'b0, 32'(ID_SPURIOUS_GRP1));
        rep(1'b1, 32'h00000028);
        wr_chk(OFS_CONTROL, EN_ALL, 1'b0);
        rep(1'b0, 32'h00000028);
        wr_chk(OFS_HIGHEST_PENDING, 32'h00000001, 1'b0);
        rep(1'b0, 32'h00000028);
        top(1'b1, 10'h00f, 1'b1, 1'b0, 3'h7);
        rep(1'b1, 32'h00001c0f);
        top(1'b1, 10'h010, 1'b1, 1'b0, 3'h7);
        rep(1'b1, 32'h00000010);
        wr_chk(OFS_CONTROL, EN_ALL & ~32'(1 << CTL_DIST_G1_BIT), 1'b0);
        rep(1'b1, 32'(ID_NONE));
        wr_chk(OFS_CONTROL, EN_ALL & ~32'(1 << CTL_CPU_G1_BIT), 1'b0);
        rep(1'b1, 32'(ID_NONE));
        wr_chk(OFS_CONTROL, EN_ALL, 1'b0);
        top(1'b1, 10'h010, 1'b1, 1'b1, 3'h0);
        rep(1'b1, 32'(ID_NONE));
        top(1'b0, 10'h010, 1'b1, 1'b0, 3'h0);
        rep(1'b0, 32'(ID_NONE));
        wr_chk(OFS_ALIASED_SPLIT, 32'h00000003, 1'b0);
        rd_chk("alias", OFS_ALIASED_SPLIT, 1'b0, 32'h00000003);
        chk("split", 32'h00000003, 32'(split));
        chk("mask", 32'h000000fc, 32'(prio_mask));
        wr_chk(OFS_ALIASED_SPLIT, 32'h00000005, 1'b1);
        rd_chk("alias ns", OFS_ALIASED_SPLIT, 1'b1, 32'h00000000);
        wr_chk(OFS_CONTROL, EN_ALL | 32'(1 << CTL_COMMON_BIT), 1'b0);
        rd_chk("alias", OFS_ALIASED_SPLIT, 1'b0, 32'h00000003);
        chk("split", 32'h00000000, 32'(split));
        chk("mask", 32'h000000ff, 32'(prio_mask));
        i_core.rd(8'h18, 1'b0, d, r);
        chk("rresp", 32'(RESP_SLVERR), 32'(r));
        rd_chk("status", OFS_IRQ_STATUS, 1'b0, ST_ALL | BAD);
        irq_chk(1'b0);
        wr_chk(OFS_IRQ_ENABLE, BAD, 1'b0);
        irq_chk(1'b1);
        wr_chk(OFS_IRQ_ENABLE, 32'h00000000, 1'b0);
        irq_chk(1'b0);
        wr_chk(OFS_IRQ_ENABLE, BAD, 1'b0);
        wr_chk(OFS_IRQ_CLEAR, BAD, 1'b0);
        irq_chk(1'b0);
        rd_chk("status", OFS_IRQ_STATUS, 1'b0, ST_ALL);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
